// [src/bsp_pkg.sv]
// Operation
// - the eight-bit organisation has two active-low nibble write masks instead of byte masks.
// - nibble masks are sampled on rising edges of both input clocks, one sample per data beat.
// - a high nibble mask leaves that stored nibble unchanged and ignores its input data.
// - each nibble mask is captured on the same edge as the data beat it qualifies.
// - the address is captured on the positive input clock rise when a read or write starts.
// - address inputs are ignored on cycles where the concerned port is not selected.
// - read data is driven on both output clock rises, or both input clock rises in single clock mode.
// - read data outputs stay driven for the whole burst, and are tri-stated on the output clock rise after its fourth word.
// - a low write select sampled on the positive input clock rise starts a write.
// - a high write select deselects the write port and write data is ignored.
// - a started write completes and the write select on the following cycle is ignored.
// - write data is sampled on rising edges of both input clocks during valid writes.
// - a low read select at the positive input clock rise starts a four-word sequential read.
package bsp_pkg;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 19;
  localparam int NIB_W   = 4;
  localparam int NIBBLES = 2;
  localparam int BURST   = 4;
  localparam int BEAT_W  = 2;
  localparam int LINK_NS = 320;
  localparam int MCLK_NS = 40;
  // samples per link period, for reference
  localparam int LINK_CYC = LINK_NS / MCLK_NS;
endpackage

// [src/bsp_edge_if.sv]
`timescale 1ns/1ps
// synchronised clock edges shared between modules
interface bsp_edge_if;
  logic kRise;
  logic kbRise;
  logic cRise;
  logic cbRise;
  modport src (output kRise, output kbRise, output cRise, output cbRise);
  modport dst (input kRise, input kbRise, input cRise, input cbRise);
endinterface

// [src/bsp_edge_det.sv]
`timescale 1ns/1ps
module bsp_edge_det
  import bsp_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // raw clocks
  input  wire logic kIn,
  input  wire logic kbIn,
  input  wire logic cIn,
  input  wire logic cbIn,
  // edges
  bsp_edge_if.src   edges
);
  logic [3:0] meta_q, meta_d;
  logic [3:0] sync_q, sync_d;
  logic [3:0] prev_q, prev_d;
  logic [3:0] rise;

  always_comb begin
    meta_d = {cbIn, cIn, kbIn, kIn};
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // idle levels {cbIn, cIn, kbIn, kIn}: no false rise after reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 4'ha;
      sync_q <= 4'ha;
      prev_q <= 4'ha;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : gRise
      assign rise[i] = sync_q[i] & ~prev_q[i];
    end
  endgenerate

  assign edges.kRise  = rise[0];
  assign edges.kbRise = rise[1];
  assign edges.cRise  = rise[2];
  assign edges.cbRise = rise[3];
endmodule

// [src/bsp_sram_ctrl.sv]
`timescale 1ns/1ps
module bsp_sram_ctrl
  import bsp_pkg::*;
#(
  parameter int DEPTH = 256
)(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  // link clocks
  input  wire logic              kClk,
  input  wire logic              kClkN,
  input  wire logic              cClk,
  input  wire logic              cClkN,
  input  wire logic              singleClk,
  // controls
  input  wire logic              readSelN,
  input  wire logic              writeSelN,
  input  wire logic [ADDR_W-1:0] shared_addr_in,
  input  wire logic [DATA_W-1:0] writeData,
  input  wire logic              low_nibble_write_mask_n,
  input  wire logic              high_nibble_write_mask_n,
  // read data
  output logic      [DATA_W-1:0] readData,
  output logic      [DATA_W-1:0] readDataOe
);
  localparam int IDX_W = $clog2(DEPTH);

  bsp_edge_if edges();

  bsp_edge_det uEdge (
    .mclk  (mclk),
    .nrst  (nrst),
    .kIn   (kClk),
    .kbIn  (kClkN),
    .cIn   (cClk),
    .cbIn  (cClkN),
    .edges (edges.src)
  );

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int SW = 4 + ADDR_W + DATA_W + NIBBLES;
  logic [SW-1:0] pinMeta_q, pinMeta_d;
  logic [SW-1:0] pin_q, pin_d;
  logic          singleMeta_q, single_q;

  always_comb begin
    pinMeta_d = {readSelN, writeSelN, shared_addr_in, writeData,
                 high_nibble_write_mask_n, low_nibble_write_mask_n, 2'h0};
    pin_d     = pinMeta_q;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pinMeta_q    <= '1;
      pin_q        <= '1;
      singleMeta_q <= 1'b0;
      single_q     <= 1'b0;
    end else begin
      pinMeta_q    <= pinMeta_d;
      pin_q        <= pin_d;
      singleMeta_q <= singleClk;
      single_q     <= singleMeta_q;
    end
  end

  // delay synchronised pins to line up with the edge detector's extra stage
  logic [SW-1:0] pinDly_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pinDly_q <= '1;
    end else begin
      pinDly_q <= pin_q;
    end
  end

  logic              rdN;
  logic              wrN;
  logic [ADDR_W-1:0] addrS;
  logic [DATA_W-1:0] dataS;
  logic [NIBBLES-1:0] maskS;
  assign rdN   = pinDly_q[SW-1];
  assign wrN   = pinDly_q[SW-2];
  assign addrS = pinDly_q[SW-3 -: ADDR_W];
  assign dataS = pinDly_q[DATA_W+NIBBLES+1 -: DATA_W];
  assign maskS = pinDly_q[3:2];

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];

  // ----------------------------------------
  // write port
  // ----------------------------------------
  typedef enum logic [1:0] {
    W_IDLE = 2'b01,
    W_BUSY = 2'b10
  } bsp_wst_e;

  bsp_wst_e          wSt_q, wSt_d;
  logic [ADDR_W-1:0] wAddr_q, wAddr_d;
  logic [BEAT_W-1:0] wBeat_q, wBeat_d;
  logic              wEn;
  logic [DATA_W-1:0] wMerged;
  logic [IDX_W-1:0]  wIdx;
  logic              dataEdge;

  assign dataEdge = edges.kRise | edges.kbRise;

  always_comb begin
    wSt_d   = wSt_q;
    wAddr_d = wAddr_q;
    wBeat_d = wBeat_q;
    wEn     = 1'b0;
    case (wSt_q)
      W_IDLE: begin
        if (edges.kRise && !wrN) begin
          wSt_d   = W_BUSY;
          wAddr_d = addrS;
          wBeat_d = '0;
        end
      end
      W_BUSY: begin
        if (dataEdge) begin
          wEn     = 1'b1;
          wBeat_d = wBeat_q + 2'h1;
          if (wBeat_q == BEAT_W'(BURST-1)) begin
            wSt_d = W_IDLE;
          end
        end
      end
      default: wSt_d = W_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wSt_q   <= W_IDLE;
      wAddr_q <= '0;
      wBeat_q <= '0;
    end else begin
      wSt_q   <= wSt_d;
      wAddr_q <= wAddr_d;
      wBeat_q <= wBeat_d;
    end
  end

  assign wIdx = IDX_W'(wAddr_q * BURST + ADDR_W'(wBeat_q));

  genvar n;
  generate
    for (n = 0; n < NIBBLES; n++) begin : gNib
      assign wMerged[n*NIB_W +: NIB_W] = maskS[n] ? mem[wIdx][n*NIB_W +: NIB_W]
                                                  : dataS[n*NIB_W +: NIB_W];
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (wEn) begin
      mem[wIdx] <= wMerged;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  typedef enum logic [2:0] {
    R_IDLE = 3'b001,
    R_WAIT = 3'b010,
    R_OUT  = 3'b100
  } bsp_rst_e;

  bsp_rst_e          rSt_q, rSt_d;
  logic [ADDR_W-1:0] rAddr_q, rAddr_d;
  logic [BEAT_W-1:0] rBeat_q, rBeat_d;
  logic [DATA_W-1:0] rData_q, rData_d;
  logic              rOe_q, rOe_d;
  logic              outEdge;
  logic [IDX_W-1:0]  rIdx;

  assign outEdge = single_q ? (edges.kRise | edges.kbRise)
                            : (edges.cRise | edges.cbRise);
  assign rIdx    = IDX_W'(rAddr_q * BURST + ADDR_W'(rBeat_q));

  always_comb begin
    rSt_d   = rSt_q;
    rAddr_d = rAddr_q;
    rBeat_d = rBeat_q;
    rData_d = rData_q;
    rOe_d   = rOe_q;
    case (rSt_q)
      R_IDLE: begin
        if (edges.kRise && !rdN) begin
          rSt_d   = R_WAIT;
          rAddr_d = addrS;
          rBeat_d = '0;
        end
      end
      R_WAIT: begin
        if (outEdge) begin
          rSt_d   = R_OUT;
          rData_d = mem[rIdx];
          rOe_d   = 1'b1;
          rBeat_d = rBeat_q + 2'h1;
        end
      end
      R_OUT: begin
        if (outEdge) begin
          if (rBeat_q == '0) begin
            rSt_d = R_IDLE;
            rOe_d = 1'b0;
          end else begin
            rData_d = mem[rIdx];
            rBeat_d = rBeat_q + 2'h1;
          end
        end
      end
      default: rSt_d = R_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rSt_q   <= R_IDLE;
      rAddr_q <= '0;
      rBeat_q <= '0;
      rData_q <= '0;
      rOe_q   <= 1'b0;
    end else begin
      rSt_q   <= rSt_d;
      rAddr_q <= rAddr_d;
      rBeat_q <= rBeat_d;
      rData_q <= rData_d;
      rOe_q   <= rOe_d;
    end
  end

  assign readData   = rData_q;
  assign readDataOe = {DATA_W{rOe_q}};
endmodule

// [bench/bsp_sram_monitor.sv]
`timescale 1ns/1ps
module bsp_sram_monitor
  import bsp_pkg::*;
(
  // clocks and reset
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       kClk,
  input wire logic       kClkN,
  input wire logic       cClk,
  input wire logic       cClkN,
  input wire logic       singleClk,
  // read side
  input wire logic       readSelN,
  input wire logic [7:0] readData,
  input wire logic [7:0] readDataOe
);
  logic [3:0] clk_q;
  logic [3:0] clk_d;
  logic [5:0] rdAge_q;
  logic [5:0] rdAge_d;
  logic [5:0] outAge_q;
  logic [5:0] outAge_d;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // cycles since read select low and since an output clock rise
  always_comb begin
    clk_d = {kClk, kClkN, cClk, cClkN};
    rdAge_d = readSelN ? rdAge_q + 6'(rdAge_q != 6'h3f) : 6'h00;
    outAge_d = outAge_q + 6'(outAge_q != 6'h3f);
    if (|(singleClk ? clk_d[3:2] & ~clk_q[3:2] : clk_d[1:0] & ~clk_q[1:0])) begin
      outAge_d = 6'h00;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clk_q <= 4'h5;
      rdAge_q <= 6'h3f;
      outAge_q <= 6'h3f;
    end else begin
      clk_q <= clk_d;
      rdAge_q <= rdAge_d;
      outAge_q <= outAge_d;
    end
  end
  sequence oeHeld;
    readDataOe[0] [*8];
  endsequence
  a_oe_whole:
    assert property (readDataOe == {8{readDataOe[0]}}) else $error("enable bits split");
  a_oe_needs_read:
    assert property ($rose(readDataOe[0]) |-> rdAge_q < 6'h18) else $error("enable unasked");
  a_oe_ends_idle:
    assert property (rdAge_q == 6'h3f |-> !readDataOe[0]) else $error("enable left on");
  a_oe_rise_edge:
    assert property ($rose(readDataOe[0]) |-> outAge_q < 6'h0a) else $error("enable off edge");
  a_oe_fall_edge:
    assert property ($fell(readDataOe[0]) |-> outAge_q < 6'h0a) else $error("release off edge");
  a_data_on_edge:
    assert property ($changed(readData) |-> outAge_q < 6'h0a) else $error("data off edge");
  a_burst_length:
    assert property ($rose(readDataOe[0]) |-> oeHeld) else $error("burst too short");
  a_word_spacing:
    assert property ($rose(readDataOe[0]) |-> ##1 $stable(readData) [*2]) else $error("word short");
endmodule
bind bsp_sram_ctrl bsp_sram_monitor mon_u (.mclk, .nrst, .kClk, .kClkN, .cClk, .cClkN,
  .singleClk, .readSelN, .readData, .readDataOe);

// [bench/bsp_ctrl_model.sv]
`timescale 1ns/1ps
module bsp_ctrl_model
  import bsp_pkg::*;
(
  // pacing
  input  wire logic   mclk,
  input  wire logic   cRun,
  // clocks and requests
  output logic        kClk,
  output logic        kClkN,
  output logic        cClk,
  output logic        cClkN,
  output logic        readSelN,
  output logic        writeSelN,
  output logic [18:0] addr,
  output logic [7:0]  wData,
  output logic [1:0]  maskN
);
  assign kClkN = ~kClk;
  assign cClkN = ~cClk;
  initial begin
    {readSelN, writeSelN, addr, wData, maskN} = {2'h3, 19'h0, 8'h0, 2'h3};
    kClk = 1'b0;
    forever #(LINK_NS / 2) kClk = ~kClk;
  end
  initial begin
    cClk = 1'b0;
    #(LINK_NS / 4);
    forever #(LINK_NS / 2) cClk = cClk ^ cRun;
  end
  // midway after the next rise, of either clock or of the negative one
  task automatic mid(input bit anyEdge);
    if (anyEdge) begin
      @(posedge kClk or posedge kClkN);
    end else begin
      @(posedge kClkN);
    end
    #1;
    repeat (2) @(negedge mclk);
  endtask
  task automatic wr(input logic [18:0] a, input logic [31:0] d, input logic [7:0] m,
                    input logic [18:0] a2, input bit hold);
    mid(1'b0);
    writeSelN = 1'b0;
    addr = a;
    for (int i = 0; i < BURST; i++) begin
      mid(1'b1);
      wData = d[31-8*i -: 8];
      maskN = m[7-2*i -: 2];
      if (i == 0) begin
        writeSelN = !hold;
        addr = a2;
      end
      if (i == 2) begin
        writeSelN = 1'b1;
      end
    end
    mid(1'b1);
    wData = ~wData;
    maskN = ~maskN;
  endtask
  task automatic rd(input logic [18:0] a);
    mid(1'b0);
    readSelN = 1'b0;
    addr = a;
    mid(1'b1);
    readSelN = 1'b1;
    addr = ~a;
  endtask
endmodule

// [bench/burst_sram_port_control_pins_bench.sv]
`timescale 1ns/1ps
module burst_sram_port_control_pins_bench
  import bsp_pkg::*;
  ;
  logic        mclk, nrst, singleClk, cRun, kClk, kClkN, cClk, cClkN, readSelN, writeSelN;
  logic [18:0] addr;
  logic [7:0]  wData, readData, readDataOe;
  logic [1:0]  maskN;
  int          failures = 0;
  int          checks = 0;
  bsp_ctrl_model model_u (.mclk, .cRun, .kClk, .kClkN, .cClk, .cClkN, .readSelN, .writeSelN,
    .addr, .wData, .maskN);
  bsp_sram_ctrl dut_u (.mclk, .nrst, .kClk, .kClkN, .cClk, .cClkN, .singleClk, .readSelN,
    .writeSelN, .shared_addr_in(addr), .writeData(wData), .low_nibble_write_mask_n(maskN[0]),
    .high_nibble_write_mask_n(maskN[1]), .readData, .readDataOe);
  task automatic complete_run;
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // read a burst, each word waited for a few cycles at most
  task automatic chk_read(input logic [18:0] a, input logic [31:0] w);
    int n;
    model_u.rd(a);
    for (int i = 0; i < BURST; i++) begin
      for (n = 0; n < 12 && !(readDataOe === 8'hff && readData === w[31-8*i -: 8]); n++) begin
        @(negedge mclk);
      end
      cmp("read word", w[31-8*i -: 8], readData);
      cmp("drive enable", 8'hff, readDataOe);
    end
    for (n = 0; n < 12 && readDataOe !== 8'h00; n++) begin
      @(negedge mclk);
    end
    cmp("release enable", 8'h00, readDataOe);
  endtask
  task automatic t_plain;
    model_u.wr(19'h3, 32'h11223344, 8'h00, 19'h7, 1'b0);
    chk_read(19'h3, 32'h11223344);
  endtask
  task automatic t_masks;
    model_u.wr(19'h3, 32'haabbccdd, 8'h1b, 19'h7, 1'b0);
    chk_read(19'h3, 32'haab23c44);
  endtask
  task automatic t_deselect;
    model_u.wr(19'h5, 32'h55667788, 8'h00, 19'h3, 1'b0);
    model_u.wr(19'h6, 32'h99eeff01, 8'h00, 19'h3, 1'b1);
    chk_read(19'h3, 32'haab23c44);
    chk_read(19'h6, 32'h99eeff01);
  endtask
  task automatic t_single;
    singleClk = 1'b1;
    cRun = 1'b0;
    chk_read(19'h5, 32'h55667788);
    singleClk = 1'b0;
    cRun = 1'b1;
  endtask
  initial begin
    mclk = 1'b0;
    forever #(MCLK_NS / 2) mclk = ~mclk;
  end
  initial begin
    nrst = 1'b0;
    singleClk = 1'b0;
    cRun = 1'b1;
    repeat (10) @(negedge mclk);
    cmp("reset enable", 8'h00, readDataOe);
    nrst = 1'b1;
    t_plain();
    t_masks();
    t_deselect();
    t_single();
    complete_run();
  end
  initial begin
    #200000;
    failures++;
    complete_run();
  end
endmodule
